// ---- hdl/aid_pkg.sv ----
// Constants and types for the adapter interrupt and i/o decode block
package aid_pkg;
  localparam logic [3:0] OPC_IO_TRANSFER = 4'hA;
  localparam int         NUM_IRQ         = 12;
  localparam int         DATA_W          = 26;
  localparam logic [8:0] JUMP_TARGET     = 9'h100; // Location 400 octal
  localparam int         DIR_BIT         = 1;      // A2 in operand bit index
  localparam int         RD_BIT          = 0;      // A1
  localparam logic [4:0] SEL_MODE        = 5'h00;
  localparam logic [4:0] SEL_DO_RESET    = 5'h01;
  localparam logic [4:0] SEL_DO_SET      = 5'h02;
  localparam logic [4:0] SEL_IC_SET      = 5'h04;
  localparam logic [4:0] SEL_IC_RESET    = 5'h05;
  localparam logic [4:0] SEL_IRQ_ACK     = 5'h06;
  localparam logic [4:0] SEL_SW_LOAD     = 5'h07;
  localparam logic [4:0] SEL_SW_IRQ_CNT  = 5'h0C;
  localparam logic [4:0] SEL_TC_READ     = 5'h0D;
  localparam logic [4:0] SEL_INHIBIT     = 5'h0E;
  localparam logic [4:0] SEL_ML_CNT      = 5'h0F;
  localparam logic [4:0] SEL_IRQ_STORE   = 5'h16; // Input group interrupt storage
  localparam logic [DATA_W-1:0] RST_WORD = '0;

  typedef enum logic [3:0] {
    AID_NONE, AID_MODE, AID_DO_RESET, AID_DO_SET, AID_IC_SET, AID_IC_RESET,
    AID_IRQ_ACK, AID_SW_LOAD, AID_SW_IRQ_CNT, AID_TC_READ, AID_INHIBIT, AID_ML_CNT
  } aid_sel_t;

  // One io transfer request from the computer
  typedef struct packed {
    logic              valid;
    logic [3:0]        opcode;
    logic [8:0]        operand;
    logic [DATA_W-1:0] data;
  } aid_req_t;
endpackage : aid_pkg

// ---- hdl/aid_adapter_irq.sv ----
// Interrupt storage, inhibit and io address decode of the data adapter
module aid_adapter_irq (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST,
  input  wire aid_pkg::aid_req_t        IO_REQ,
  input  wire logic                     INSTR_DONE,
  input  wire logic [aid_pkg::NUM_IRQ-1:0] IRQ_SRC,
  input  wire logic [aid_pkg::DATA_W-1:0]  TC_ERR_IN,
  output logic [aid_pkg::DATA_W-1:0]    MODE_REG,
  output logic [aid_pkg::DATA_W-1:0]    DISC_OUT,
  output logic [aid_pkg::DATA_W-1:0]    INT_CTRL,
  output logic [aid_pkg::DATA_W-1:0]    SW_SEL,
  output logic [aid_pkg::DATA_W-1:0]    SW_IRQ_CNT,
  output logic [aid_pkg::DATA_W-1:0]    ML_CNT,
  output logic [aid_pkg::NUM_IRQ-1:0]   IRQ_MASK,
  output logic [aid_pkg::NUM_IRQ-1:0]   IRQ_STORE,
  output logic [aid_pkg::NUM_IRQ-1:0]   IRQ_SUPPR,
  output logic [aid_pkg::DATA_W-1:0]    RD_DATA,
  output logic                          RD_VALID,
  output logic                          SECTOR_JUMP,
  output logic [8:0]                    JUMP_ADDR
);
  import aid_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] src_m_q;
  logic [NUM_IRQ-1:0] src_q;
  logic [DATA_W-1:0]  tc_m_q;
  logic [DATA_W-1:0]  tc_q;

  // Two stages for the external conditions
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      src_m_q <= '0;
      src_q   <= '0;
      tc_m_q  <= '0;
      tc_q    <= '0;
    end else begin
      src_m_q <= IRQ_SRC;
      src_q   <= src_m_q;
      tc_m_q  <= TC_ERR_IN;
      tc_q    <= tc_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Map the A7..A3 field to an output selection
  function automatic aid_sel_t dec_out(input logic [4:0] code);
    unique case (code)
      SEL_MODE:       dec_out = AID_MODE;
      SEL_DO_RESET:   dec_out = AID_DO_RESET;
      SEL_DO_SET:     dec_out = AID_DO_SET;
      SEL_IC_SET:     dec_out = AID_IC_SET;
      SEL_IC_RESET:   dec_out = AID_IC_RESET;
      SEL_IRQ_ACK:    dec_out = AID_IRQ_ACK;
      SEL_SW_LOAD:    dec_out = AID_SW_LOAD;
      SEL_SW_IRQ_CNT: dec_out = AID_SW_IRQ_CNT;
      SEL_TC_READ:    dec_out = AID_TC_READ;
      SEL_INHIBIT:    dec_out = AID_INHIBIT;
      SEL_ML_CNT:     dec_out = AID_ML_CNT;
      default:        dec_out = AID_NONE;
    endcase
  endfunction : dec_out

  logic     is_io;
  logic     is_wr;
  logic     is_rd;
  aid_sel_t sel;
  logic [DATA_W-1:0] wdat;

  assign is_io = IO_REQ.valid && (IO_REQ.opcode == OPC_IO_TRANSFER);
  assign is_wr = is_io && IO_REQ.operand[DIR_BIT] && !IO_REQ.operand[RD_BIT];
  assign is_rd = is_io && IO_REQ.operand[DIR_BIT] && IO_REQ.operand[RD_BIT];
  assign sel  = dec_out(IO_REQ.operand[6:2]);
  assign wdat = IO_REQ.data;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Mode, discrete outputs and switch selector
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      MODE_REG <= RST_WORD;
      DISC_OUT <= RST_WORD;
      SW_SEL   <= RST_WORD;
    end else if (is_wr) begin
      if (sel == AID_MODE) MODE_REG <= wdat;
      if (sel == AID_DO_RESET) DISC_OUT <= DISC_OUT & ~wdat;
      if (sel == AID_DO_SET) DISC_OUT <= DISC_OUT | wdat;
      if (sel == AID_SW_LOAD) SW_SEL <= wdat;
    end
  end

  // Internal control set and reset
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      INT_CTRL <= RST_WORD;
    end else if (is_wr) begin
      if (sel == AID_IC_SET) INT_CTRL <= INT_CTRL | wdat;
      if (sel == AID_IC_RESET) INT_CTRL <= INT_CTRL & ~wdat;
    end
  end

  // Counters and inhibit mask loaded from the computer
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SW_IRQ_CNT <= RST_WORD;
      ML_CNT     <= RST_WORD;
      IRQ_MASK   <= '0;
    end else if (is_wr) begin
      if (sel == AID_SW_IRQ_CNT) SW_IRQ_CNT <= wdat;
      if (sel == AID_ML_CNT) ML_CNT <= wdat;
      if (sel == AID_INHIBIT) IRQ_MASK <= wdat[NUM_IRQ-1:0];
    end
  end

  // Reads into the accumulator
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RD_DATA  <= RST_WORD;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= is_rd;
      if (is_rd) begin
        if (IO_REQ.operand[6:2] == SEL_TC_READ) RD_DATA <= tc_q;
        else if (IO_REQ.operand[6:2] == SEL_IRQ_STORE)
          RD_DATA <= {{(DATA_W-NUM_IRQ){1'b0}}, IRQ_STORE};
        else RD_DATA <= RST_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt storage and suppression
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] ack;
  logic [NUM_IRQ-1:0] src_prev_q;
  logic [NUM_IRQ-1:0] rise;

  assign ack  = (is_wr && sel == AID_IRQ_ACK) ? wdat[NUM_IRQ-1:0] : '0;
  assign rise = src_q & ~src_prev_q & ~IRQ_SUPPR;

  logic [NUM_IRQ-1:0] ack_clr;
  logic [NUM_IRQ-1:0] ack_hold;
  // Acknowledged bits with no fresh edge, and those whose source still stands
  assign ack_clr  = ack & ~rise;
  assign ack_hold = ack & src_q;

  // twelve storage bits, set wins over clear
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      src_prev_q <= '0;
      IRQ_STORE  <= '0;
    end else begin
      src_prev_q <= src_q;
      IRQ_STORE <= (IRQ_STORE & ~ack) | rise;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IRQ_SUPPR <= '0;
    end else begin
      IRQ_SUPPR <= (IRQ_SUPPR | (ack & src_q)) & src_q;
    end
  end

  // ----------------------------------------------------------------
  // Forced jump
  // ----------------------------------------------------------------
  logic pending;
  assign pending = |(IRQ_STORE & ~IRQ_SUPPR & ~IRQ_MASK);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SECTOR_JUMP <= 1'b0;
      JUMP_ADDR   <= '0;
    end else begin
      SECTOR_JUMP <= pending && INSTR_DONE;
      JUMP_ADDR   <= JUMP_TARGET;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_jump;
    @(posedge SYS_CLK) disable iff (RST)
      (pending && INSTR_DONE) |=> (SECTOR_JUMP && JUMP_ADDR == JUMP_TARGET);
  endproperty
  a_jump: assert property (p_jump) else $error("jump not forced");

  property p_nojump;
    @(posedge SYS_CLK) disable iff (RST)
      !(pending && INSTR_DONE) |=> !SECTOR_JUMP;
  endproperty
  a_nojump: assert property (p_nojump) else $error("spurious jump");

  property p_ack_clear;
    @(posedge SYS_CLK) disable iff (RST)
      (ack_clr != '0) |=> ((IRQ_STORE & $past(ack_clr)) == '0);
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear");

  property p_keep;
    @(posedge SYS_CLK) disable iff (RST)
      (IRQ_STORE != '0) |=> ((($past(IRQ_STORE) & ~$past(ack)) & ~IRQ_STORE) == '0);
  endproperty
  a_keep: assert property (p_keep) else $error("stored bit lost");

  property p_suppr;
    @(posedge SYS_CLK) disable iff (RST)
      (ack_hold != '0) |=> ((IRQ_SUPPR & $past(ack_hold)) == $past(ack_hold));
  endproperty
  a_suppr: assert property (p_suppr) else $error("no suppression");

  property p_release;
    @(posedge SYS_CLK) disable iff (RST)
      (IRQ_SUPPR != '0) |=> ((IRQ_SUPPR & ~$past(src_q)) == '0);
  endproperty
  a_release: assert property (p_release) else $error("suppression stuck");

  property p_mode;
    @(posedge SYS_CLK) disable iff (RST)
      (is_wr && IO_REQ.operand[6:2] == 5'h00) |=> MODE_REG == $past(wdat);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not loaded");

  property p_icset;
    @(posedge SYS_CLK) disable iff (RST)
      (is_wr && IO_REQ.operand[6:2] == 5'h04) |=> ((INT_CTRL & $past(wdat)) == $past(wdat));
  endproperty
  a_icset: assert property (p_icset) else $error("control set failed");

  property p_swld;
    @(posedge SYS_CLK) disable iff (RST)
      (is_wr && IO_REQ.operand[6:2] == 5'h07) |=> SW_SEL == $past(wdat);
  endproperty
  a_swld: assert property (p_swld) else $error("selector not loaded");

  property p_rdv;
    @(posedge SYS_CLK) disable iff (RST)
      (IO_REQ.valid && IO_REQ.opcode == OPC_IO_TRANSFER && IO_REQ.operand[1:0] == 2'b11)
        |=> RD_VALID;
  endproperty
  a_rdv: assert property (p_rdv) else $error("read not answered");
endmodule : aid_adapter_irq

// ---- verification/aid_cpu_model.sv ----
// Computer side model: issues io transfer instructions and completion pulses
module aid_cpu_model import aid_pkg::*; (
  input  wire logic              sys_clk,
  output aid_pkg::aid_req_t      io_req,
  output logic                   instr_done
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus shows no valid request
  initial begin
    io_req = '0;
    instr_done = 1'b0;
  end
  task automatic issue(input logic [3:0] opc, input logic [8:0] opnd, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    #2;
    io_req = '{valid: 1'b1, opcode: opc, operand: opnd, data: d};
    @(posedge sys_clk);
    #2;
    io_req = '{valid: 1'b0, opcode: ~opc, operand: ~opnd, data: ~d}; // Stale lines inverted
  endtask : issue
  task automatic wr(input logic [4:0] sel, input logic [DATA_W-1:0] d);
    issue(OPC_IO_TRANSFER, {2'b00, sel, 2'b10}, d);
  endtask : wr
  task automatic rd(input logic [4:0] sel);
    issue(OPC_IO_TRANSFER, {2'b00, sel, 2'b11}, '0);
  endtask : rd
  task automatic ack(input logic [NUM_IRQ-1:0] bits);
    wr(SEL_IRQ_ACK, DATA_W'(bits));
  endtask : ack
  // Instruction completion pulse
  task automatic done();
    @(posedge sys_clk);
    #2;
    instr_done = 1'b1;
    @(posedge sys_clk);
    #2;
    instr_done = 1'b0;
  endtask : done
endmodule : aid_cpu_model

// ---- verification/tb_aid_adapter_irq.sv ----
// Testbench for the adapter interrupt and io decode block
module tb_aid_adapter_irq import aid_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rst, instr_done, rd_valid, sector_jump;
  aid_req_t io_req;
  logic [NUM_IRQ-1:0] irq_src, irq_mask, irq_store, irq_suppr;
  logic [DATA_W-1:0] tc_err_in, mode_reg, disc_out, int_ctrl, sw_sel, sw_irq_cnt, ml_cnt, rd_data, v, w;
  logic [8:0] jump_addr;
  logic [DATA_W-1:0] rd_q[$];
  logic [31:0] seed = 32'h08B9FE89;
  int fail_count = 0, n_tests = 0, cycles = 0;
  aid_cpu_model i_aid_cpu_model (.sys_clk(sys_clk), .io_req(io_req), .instr_done(instr_done));
  aid_adapter_irq i_aid_adapter_irq (.SYS_CLK(sys_clk), .RST(rst), .IO_REQ(io_req),
    .INSTR_DONE(instr_done), .IRQ_SRC(irq_src), .TC_ERR_IN(tc_err_in), .MODE_REG(mode_reg),
    .DISC_OUT(disc_out), .INT_CTRL(int_ctrl), .SW_SEL(sw_sel), .SW_IRQ_CNT(sw_irq_cnt),
    .ML_CNT(ml_cnt), .IRQ_MASK(irq_mask), .IRQ_STORE(irq_store), .IRQ_SUPPR(irq_suppr),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .SECTOR_JUMP(sector_jump), .JUMP_ADDR(jump_addr));
  always #12.5 sys_clk = ~sys_clk;
  function automatic logic [DATA_W-1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return DATA_W'(seed);
  endfunction : rnd
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic wait_sync();
    repeat (5) @(posedge sys_clk);
    #2;
  endtask : wait_sync
  // Read watcher takes the oldest expected word
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (rd_q.size() == 0) chk("rd_extra", '0, '1);
      else chk("rd_data", rd_q.pop_front(), rd_data);
    end
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial begin
    rst = 1'b1;
    irq_src = '0;
    tc_err_in = '0;
    repeat (16) @(posedge sys_clk);
    #2 rst = 1'b0;
    @(posedge sys_clk);
    #2;
    chk("jump_addr", DATA_W'(JUMP_TARGET), DATA_W'(jump_addr));
    chk("mode_rst", '0, mode_reg);
    v = rnd(); i_aid_cpu_model.wr(SEL_MODE, v); chk("mode", v, mode_reg);
    v = rnd(); i_aid_cpu_model.wr(SEL_SW_LOAD, v); chk("sw_sel", v, sw_sel);
    v = rnd(); i_aid_cpu_model.wr(SEL_SW_IRQ_CNT, v); chk("sw_cnt", v, sw_irq_cnt);
    v = rnd(); i_aid_cpu_model.wr(SEL_ML_CNT, v); chk("ml_cnt", v, ml_cnt);
    v = rnd(); w = rnd(); i_aid_cpu_model.wr(SEL_DO_SET, v); chk("do_set", v, disc_out);
    i_aid_cpu_model.wr(SEL_DO_RESET, w); chk("do_reset", v & ~w, disc_out);
    v = rnd(); w = rnd(); i_aid_cpu_model.wr(SEL_IC_SET, v); chk("ic_set", v, int_ctrl);
    i_aid_cpu_model.wr(SEL_IC_RESET, w); chk("ic_reset", v & ~w, int_ctrl);
    v = mode_reg;
    i_aid_cpu_model.issue(4'h9, {2'b00, SEL_MODE, 2'b10}, ~v); chk("bad_op", v, mode_reg);
    i_aid_cpu_model.issue(OPC_IO_TRANSFER, 9'h000, ~v); chk("a2_low", v, mode_reg);
    $display("test decode done");
    tc_err_in = rnd(); wait_sync(); rd_q.push_back(tc_err_in);
    i_aid_cpu_model.rd(SEL_TC_READ);
    rd_q.push_back('0); i_aid_cpu_model.rd(5'h1F);
    irq_src[3] = 1'b1; wait_sync(); chk("store", 12'h008, irq_store);
    i_aid_cpu_model.done(); chk("jump", 1'b1, sector_jump);
    rd_q.push_back(12'h008); i_aid_cpu_model.rd(SEL_IRQ_STORE);
    i_aid_cpu_model.ack(12'h008); chk("ack_store", '0, irq_store);
    chk("suppr", 12'h008, irq_suppr);
    i_aid_cpu_model.done(); chk("no_jump", 1'b0, sector_jump);
    irq_src[3] = 1'b0; wait_sync(); chk("unsuppr", '0, irq_suppr);
    irq_src[3] = 1'b1; wait_sync(); chk("restore", 12'h008, irq_store);
    i_aid_cpu_model.ack(12'h020); chk("ack_other", 12'h008, irq_store);
    irq_src[3] = 1'b0; wait_sync(); i_aid_cpu_model.ack(12'h008);
    chk("ack_low", '0, irq_store | irq_suppr);
    i_aid_cpu_model.wr(SEL_INHIBIT, 12'h020); chk("mask", 12'h020, irq_mask);
    irq_src[5] = 1'b1; wait_sync(); chk("store5", 12'h020, irq_store);
    i_aid_cpu_model.done(); chk("masked", 1'b0, sector_jump);
    // Random set of sources: store, jump, suppress and release
    i_aid_cpu_model.wr(SEL_INHIBIT, '0);
    irq_src = '0;
    wait_sync();
    i_aid_cpu_model.ack('1); chk("ack_all", '0, irq_store | irq_suppr);
    w = rnd();
    irq_src = w[NUM_IRQ-1:0] | 12'h001;
    wait_sync();
    chk("store_rnd", DATA_W'(irq_src), irq_store);
    i_aid_cpu_model.done(); chk("jump_rnd", 1'b1, sector_jump);
    i_aid_cpu_model.ack(irq_src); chk("suppr_rnd", DATA_W'(irq_src), irq_suppr);
    chk("clr_rnd", '0, irq_store);
    i_aid_cpu_model.done(); chk("held_rnd", 1'b0, sector_jump);
    irq_src = '0;
    wait_sync();
    chk("free_rnd", '0, irq_suppr);
    chk("rd_left", '0, DATA_W'(rd_q.size()));
    repeat (2) @(posedge sys_clk);
    $display("test interrupt done");
    stop_test();
  end
endmodule : tb_aid_adapter_irq
